// ### rtl/rsq_consts.vh
// constants of the reset initialization sequencer
`ifndef RSQ_CONSTS_VH
`define RSQ_CONSTS_VH

// ****************************************************************
// register map
// ****************************************************************
`define RSQ_ADDR_W           4
`define RSQ_OFF_CTRL         4'h0
`define RSQ_OFF_STATUS       4'h4
`define RSQ_OFF_STRAPS       4'h8

// control register fields
`define RSQ_CTRL_HRST_REQ    0
`define RSQ_CTRL_SRST_DRV    1
`define RSQ_CTRL_RESET       32'h0000_0000

// status register fields
`define RSQ_ST_STATE_LO      0
`define RSQ_ST_STATE_HI      1
`define RSQ_ST_LOCKED        2
`define RSQ_ST_TIMEOUT       3
`define RSQ_ST_FUNC_DRV      4
`define RSQ_ST_LINE_LVL      5
`define RSQ_ST_AGENT         6

// strap register fields
`define RSQ_SP_SRC_LO        0
`define RSQ_SP_SRC_HI        3
`define RSQ_SP_DIV           4
`define RSQ_SP_LBMUX         5

// ****************************************************************
// timing
// ****************************************************************
`define RSQ_CLK_MHZ          100
`define RSQ_HOLD_TICKS       512
`define RSQ_GAP_TICKS        16
`define RSQ_EXT_TICKS        32
`define RSQ_FUNC_TICKS       1
`define RSQ_LOCK_US          100
`define RSQ_LOCK_CYCLES      (`RSQ_LOCK_US * `RSQ_CLK_MHZ)
`define RSQ_TURNOFF_NS       4
`define RSQ_STRAP_W          6

`endif

// ### rtl/rsq_sync.v
// two flip-flop synchroniser for pin-level inputs
module rsq_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// asynchronous levels in, synchronous levels out
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// the first stage feeds only the second stage
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;

endmodule

// ### rtl/rsq_top.v
// reset initialization sequencer: strap capture, hard reset drive, pin release
`include "rsq_consts.vh"

module rsq_top #(
	parameter HOLD_TICKS  = `RSQ_HOLD_TICKS,
	parameter GAP_TICKS   = `RSQ_GAP_TICKS,
	parameter EXT_TICKS   = `RSQ_EXT_TICKS,
	parameter FUNC_TICKS  = `RSQ_FUNC_TICKS,
	parameter LOCK_CYCLES = `RSQ_LOCK_CYCLES
) (
	// clock and reset
	input  wire                     clk_i,
	input  wire                     rst_i,
	// reset pins
	input  wire                     power_on_reset_in_n_i,
	input  wire                     hard_reset_line_i,
	output wire                     hard_reset_line_o,
	output wire                     hard_reset_line_oe_n_o,
	input  wire                     soft_reset_line_i,
	output wire                     soft_reset_line_o,
	output wire                     soft_reset_line_oe_n_o,
	// clock pins and mode
	input  wire                     primary_clock_input_i,
	input  wire                     agent_clock_input_i,
	input  wire                     agent_mode_i,
	input  wire                     pll_lock_i,
	// shared strap pins: source[3:0], divide, bus mux
	input  wire [`RSQ_STRAP_W-1:0]  strap_pin_i,
	output wire [`RSQ_STRAP_W-1:0]  strap_pin_o,
	output wire [`RSQ_STRAP_W-1:0]  strap_pin_oe_n_o,
	input  wire [`RSQ_STRAP_W-1:0]  func_out_i,
	// latched configuration and core reset
	output wire [3:0]               reset_source_strap_o,
	output wire                     input_clock_divide_strap_o,
	output wire                     local_bus_mux_strap_o,
	output wire                     core_reset_o,
	// register port
	input  wire [`RSQ_ADDR_W-1:0]   reg_addr_i,
	input  wire [31:0]              reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output wire [31:0]              reg_rdata_o
);

	// ****************************************************************
	// states and storage
	// ****************************************************************
	localparam [1:0] ST_POR     = 2'h0;
	localparam [1:0] ST_ASSERT  = 2'h1;
	localparam [1:0] ST_RELEASE = 2'h2;
	localparam [1:0] ST_RUN     = 2'h3;
	localparam [9:0] HOLD_N     = HOLD_TICKS;
	localparam [9:0] GAP_N      = GAP_TICKS;
	localparam [9:0] EXT_N      = EXT_TICKS;
	localparam [9:0] FUNC_N     = FUNC_TICKS;
	localparam [15:0] LOCK_N    = LOCK_CYCLES;

	reg [1:0]               state_reg, state_next;
	reg [9:0]               cnt_reg, cnt_next;
	reg [9:0]               gap_reg, gap_next;
	reg [9:0]               ext_reg, ext_next;
	reg [15:0]              lock_reg, lock_next;
	reg                     timeout_reg, timeout_next;
	reg [`RSQ_STRAP_W-1:0]  straps_reg, straps_next;
	reg                     agent_reg, agent_next;
	reg                     func_drv_reg;
	reg [`RSQ_STRAP_W-1:0]  func_data_reg;
	reg [31:0]              ctrl_reg;
	reg [31:0]              rdata_reg;
	reg                     pclk_d_reg, aclk_d_reg, div_ph_reg;

	wire [11:0]             sync_in;
	wire                    por_n_s, line_s, pclk_s, aclk_s, lock_s, agent_s;
	wire [`RSQ_STRAP_W-1:0] strap_s;
	wire                    pclk_rise, aclk_rise, tick;
	wire                    mode_agent, div_sel, hrst_req, line_low_n;

	// ****************************************************************
	// pin synchronisation and sync clock tick
	// ****************************************************************
	// every pin level but the soft reset line passes two flops; the clock pins are sampled as levels
	rsq_sync #(
		.W (12)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({power_on_reset_in_n_i, hard_reset_line_i, primary_clock_input_i,
		         agent_clock_input_i, pll_lock_i, agent_mode_i, strap_pin_i}),
		.q_o   (sync_in)
	);

	assign por_n_s = sync_in[11];
	assign line_s  = sync_in[10];
	assign pclk_s  = sync_in[9];
	assign aclk_s  = sync_in[8];
	assign lock_s  = sync_in[7];
	assign agent_s = sync_in[6];
	assign strap_s = sync_in[5:0];

	// before the straps are latched the live divide strap steers the tick
	assign mode_agent = (state_reg == ST_POR) ? agent_s : agent_reg;
	assign div_sel    = (state_reg == ST_POR) ? strap_s[`RSQ_SP_DIV] : straps_reg[`RSQ_SP_DIV];
	assign pclk_rise  = pclk_s & ~pclk_d_reg;
	assign aclk_rise  = aclk_s & ~aclk_d_reg;
	// host: primary edges, every other one when the divide strap is set; agent: agent clock edges only
	assign tick = mode_agent ? aclk_rise
	            : (pclk_rise & (~div_sel | div_ph_reg));

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pclk_d_reg <= 1'b0;
			aclk_d_reg <= 1'b0;
			div_ph_reg <= 1'b0;
		end
		else
		begin
			pclk_d_reg <= pclk_s;
			aclk_d_reg <= aclk_s;
			if (pclk_rise)
				div_ph_reg <= ~div_ph_reg;
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	assign hrst_req   = ctrl_reg[`RSQ_CTRL_HRST_REQ];
	assign line_low_n = line_s;

	// next-state logic; counters saturate so they never wrap
	always @*
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		gap_next     = gap_reg;
		ext_next     = ext_reg;
		lock_next    = lock_reg;
		timeout_next = timeout_reg;
		straps_next  = straps_reg;
		agent_next   = agent_reg;
		case (state_reg)
			ST_POR:
			begin
				// straps meet their setup before the release, so take them now
				if (por_n_s)
				begin
					straps_next = strap_s;
					agent_next  = agent_s;
					state_next  = ST_ASSERT;
					cnt_next    = 10'h000;
					lock_next   = 16'h0000;
				end
			end
			ST_ASSERT:
			begin
				if (tick && cnt_reg != HOLD_N)
					cnt_next = cnt_reg + 10'h001;
				if (!lock_s && lock_reg != LOCK_N)
					lock_next = lock_reg + 16'h0001;
				// a missed lock is flagged; the line stays held until lock
				if (!lock_s && lock_reg == LOCK_N - 16'h0001)
					timeout_next = 1'b1;
				if (cnt_reg == HOLD_N && lock_s)
				begin
					state_next = ST_RELEASE;
					cnt_next   = 10'h000;
					gap_next   = 10'h000;
				end
			end
			ST_RELEASE:
			begin
				if (tick && gap_reg != GAP_N)
					gap_next = gap_reg + 10'h001;
				// one extra edge so a full period passes after the line rises
				if (!line_low_n)
					cnt_next = 10'h000;
				else if (tick && cnt_reg != FUNC_N + 10'h001)
					cnt_next = cnt_reg + 10'h001;
				if (line_low_n && cnt_reg == FUNC_N + 10'h001)
				begin
					state_next = ST_RUN;
					ext_next   = 10'h000;
				end
			end
			ST_RUN:
			begin
				if (tick && gap_reg != GAP_N)
					gap_next = gap_reg + 10'h001;
				if (line_low_n)
					ext_next = 10'h000;
				else if (tick && ext_reg != EXT_N)
					ext_next = ext_reg + 10'h001;
				// outside pulse long enough, or software request, restarts
				if ((ext_reg == EXT_N || hrst_req) && gap_reg == GAP_N)
				begin
					state_next = ST_ASSERT;
					cnt_next   = 10'h000;
					lock_next  = 16'h0000;
				end
			end
			default:
				state_next = ST_POR;
		endcase
		// power-on reset overrides every state
		if (!por_n_s)
			state_next = ST_POR;
		// clear by writing one; a timeout in the same cycle wins only while the flag is clear
		if (reg_wr_i && reg_addr_i == `RSQ_OFF_STATUS &&
		    reg_wdata_i[`RSQ_ST_TIMEOUT] && !(timeout_next && !timeout_reg))
			timeout_next = 1'b0;
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg   <= ST_POR;
			cnt_reg     <= 10'h000;
			gap_reg     <= 10'h000;
			ext_reg     <= 10'h000;
			lock_reg    <= 16'h0000;
			timeout_reg <= 1'b0;
			straps_reg  <= {`RSQ_STRAP_W{1'b0}};
			agent_reg   <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			gap_reg     <= gap_next;
			ext_reg     <= ext_next;
			lock_reg    <= lock_next;
			timeout_reg <= timeout_next;
			straps_reg  <= straps_next;
			agent_reg   <= agent_next;
		end
	end

	// ****************************************************************
	// pins
	// ****************************************************************
	// functional drive only in run; data registered from the user side
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			func_drv_reg  <= 1'b0;
			func_data_reg <= {`RSQ_STRAP_W{1'b0}};
		end
		else
		begin
			func_drv_reg  <= (state_next == ST_RUN);
			func_data_reg <= func_out_i;
		end
	end

	// reset lines only ever pull low; the enable alone carries the level
	assign hard_reset_line_o      = 1'b0;
	assign hard_reset_line_oe_n_o = ~(state_reg == ST_ASSERT) | ~por_n_s;
	assign soft_reset_line_o      = 1'b0;
	assign soft_reset_line_oe_n_o = ~ctrl_reg[`RSQ_CTRL_SRST_DRV];

	// the raw pin gates the enable: a synchroniser is far slower than 4 ns
	assign strap_pin_o      = func_data_reg;
	assign strap_pin_oe_n_o = {`RSQ_STRAP_W{~(func_drv_reg & hard_reset_line_i)}};

	// straps stay valid until the line negates, so latched values hold
	assign reset_source_strap_o       = straps_reg[`RSQ_SP_SRC_HI:`RSQ_SP_SRC_LO];
	assign input_clock_divide_strap_o = straps_reg[`RSQ_SP_DIV];
	assign local_bus_mux_strap_o      = straps_reg[`RSQ_SP_LBMUX];
	assign core_reset_o               = ~func_drv_reg;

	// ****************************************************************
	// register port
	// ****************************************************************
	// hard reset request is a pulse bit; it clears once the flow restarts
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			ctrl_reg <= `RSQ_CTRL_RESET;
		else if (reg_wr_i && reg_addr_i == `RSQ_OFF_CTRL)
			ctrl_reg <= {30'h0000_0000, reg_wdata_i[`RSQ_CTRL_SRST_DRV],
			             reg_wdata_i[`RSQ_CTRL_HRST_REQ]};
		else if (state_reg == ST_ASSERT)
			ctrl_reg[`RSQ_CTRL_HRST_REQ] <= 1'b0;
	end

	// read data stand one cycle after the strobe; unmapped reads give zero
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_reg <= 32'h0000_0000;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`RSQ_OFF_CTRL:   rdata_reg <= ctrl_reg;
				`RSQ_OFF_STATUS: rdata_reg <= {25'h000_0000, agent_reg, line_s, func_drv_reg,
				                               timeout_reg, lock_s, state_reg};
				`RSQ_OFF_STRAPS: rdata_reg <= {26'h000_0000, straps_reg};
				default:         rdata_reg <= 32'h0000_0000;
			endcase
		end
		else
			rdata_reg <= 32'h0000_0000;
	end

	assign reg_rdata_o = rdata_reg;

endmodule

// ### verif/rsq_asserts.sv
// port assertions for the reset initialization sequencer
module rsq_asserts #(
	parameter HOLD_TICKS = 512,
	parameter GAP_TICKS  = 16,
	parameter FUNC_TICKS = 1
) (
	// clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// reset and clock pins
	input wire        power_on_reset_in_n_i,
	input wire        hard_reset_line_i,
	input wire        hard_reset_line_o,
	input wire        hard_reset_line_oe_n_o,
	input wire        soft_reset_line_o,
	input wire        primary_clock_input_i,
	input wire        pll_lock_i,
	// strap pins and core
	input wire [5:0]  strap_pin_oe_n_o,
	input wire [3:0]  reset_source_strap_o,
	input wire        core_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk_q;
	logic [15:0] low_cnt;
	logic [15:0] gap_cnt;
	logic [15:0] hi_cnt;
	wire         tick = primary_clock_input_i & ~pclk_q;
	// raw tick counts; the gap and high counts saturate, the low count does not
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pclk_q  <= 1'b0;
			low_cnt <= 16'h0;
			gap_cnt <= 16'hffff;
			hi_cnt  <= 16'h0;
		end
		else
		begin
			pclk_q  <= primary_clock_input_i;
			low_cnt <= hard_reset_line_oe_n_o ? 16'h0 : low_cnt + {15'h0, tick};
			gap_cnt <= !power_on_reset_in_n_i ? 16'hffff : !hard_reset_line_oe_n_o ? 16'h0
				: gap_cnt + {15'h0, tick & ~&gap_cnt};
			hi_cnt  <= !hard_reset_line_i ? 16'h0 : hi_cnt + {15'h0, tick & ~&hi_cnt};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// the synchroniser lag may hide one raw edge, hence the minus one
	hold_min_a: assert property ($rose(hard_reset_line_oe_n_o) && power_on_reset_in_n_i
		|-> low_cnt >= HOLD_TICKS - 1) else $error("hard reset released early");
	neg_gap_a: assert property ($fell(hard_reset_line_oe_n_o) && power_on_reset_in_n_i
		|-> gap_cnt >= GAP_TICKS - 1) else $error("hard reset restarted too soon");
	func_late_a: assert property ($fell(strap_pin_oe_n_o[0]) |-> hi_cnt >= FUNC_TICKS)
		else $error("strap pins driven too early");
	strap_off_a: assert property (!hard_reset_line_i |-> strap_pin_oe_n_o == 6'h3f)
		else $error("strap pins driven during hard reset");
	drain_only_a: assert property (!hard_reset_line_o && !soft_reset_line_o)
		else $error("reset line data not low");
	lock_gate_a: assert property ($rose(hard_reset_line_oe_n_o) && power_on_reset_in_n_i
		|-> $past(pll_lock_i, 3)) else $error("released without lock");
	latch_hold_a: assert property (!core_reset_o |-> $stable(reset_source_strap_o))
		else $error("straps changed while running");
	core_run_a: assert property (!core_reset_o && hard_reset_line_i
		|-> strap_pin_oe_n_o == 6'h00) else $error("running without pin drive");
	cover property ($fell(hard_reset_line_oe_n_o));
	cover property ($rose(hard_reset_line_oe_n_o));
	cover property ($fell(strap_pin_oe_n_o[0]));
endmodule

bind rsq_top rsq_asserts #(.HOLD_TICKS(HOLD_TICKS), .GAP_TICKS(GAP_TICKS), .FUNC_TICKS(FUNC_TICKS))
	u_rsq_asserts (.clk_i, .rst_i, .power_on_reset_in_n_i, .hard_reset_line_i, .hard_reset_line_o,
	.hard_reset_line_oe_n_o, .soft_reset_line_o, .primary_clock_input_i, .pll_lock_i,
	.strap_pin_oe_n_o, .reset_source_strap_o, .core_reset_o);

// ### verif/rsq_board.sv
// board supervisor, strap drivers and pull-ups beside the sequencer
module rsq_board (
	// requests from the bench
	input wire         por_req_i,
	input wire         ext_req_i,
	input wire [5:0]   straps_i,
	// device enables and data
	input wire         hard_oe_n_i,
	input wire         soft_oe_n_i,
	input wire [5:0]   strap_oe_n_i,
	input wire [5:0]   strap_d_i,
	// resolved pins
	output logic       por_n_o,
	output logic       pclk_o,
	output logic       lock_o,
	output wire        hard_line_o,
	output wire        soft_line_o,
	output wire  [5:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ext_low;
	logic valid;
	// free-running primary clock, slow enough for the pin sampler
	initial
	begin
		pclk_o = 1'b0;
		forever #40 pclk_o = ~pclk_o;
	end
	initial
	begin
		por_n_o = 1'b0;
		lock_o  = 1'b0;
		ext_low = 1'b0;
		valid   = 1'b1;
	end
	// power-on: straps valid, 32 stable periods, lock comes late on purpose
	always @(posedge por_req_i)
	begin
		por_n_o = 1'b0;
		lock_o  = 1'b0;
		valid   = 1'b1;
		repeat (32) @(posedge pclk_o);
		por_n_o = 1'b1;
		repeat (20) @(posedge pclk_o);
		lock_o  = 1'b1;
	end
	// outside hard reset, held past the 32 period minimum
	always @(posedge ext_req_i)
	begin
		ext_low = 1'b1;
		repeat (40) @(posedge pclk_o);
		ext_low = 1'b0;
	end
	// straps held until the line negates, then shown inverted
	always @(posedge hard_line_o)
		if (por_n_o)
			valid = 1'b0;
	// pulled-up open-drain wires
	assign hard_line_o = hard_oe_n_i & ~ext_low;
	assign soft_line_o = soft_oe_n_i;
	assign pin_o = (strap_d_i & ~strap_oe_n_i) | ((valid ? straps_i : ~straps_i) & strap_oe_n_i);
endmodule

// ### verif/rsq_top_tb.sv
// self-checking bench for the reset initialization sequencer
module rsq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, por_req, ext_req, reg_wr_i, reg_rd_i, agent_mode;
	logic [5:0]  straps, func_out_i;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	wire         power_on_reset_in_n_i, hard_reset_line_i, soft_reset_line_i;
	wire         primary_clock_input_i, pll_lock_i, hard_reset_line_o, hard_reset_line_oe_n_o;
	wire         soft_reset_line_o, soft_reset_line_oe_n_o, core_reset_o;
	wire         input_clock_divide_strap_o, local_bus_mux_strap_o;
	wire [5:0]   strap_pin_i, strap_pin_o, strap_pin_oe_n_o;
	wire [3:0]   reset_source_strap_o;
	wire [31:0]  reg_rdata_o;
	int          n_fail, comparisons;
	// short hold and lock limits keep the run brief
	rsq_top #(.HOLD_TICKS(8), .LOCK_CYCLES(50)) u_rsq_top (.clk_i, .rst_i,
		.power_on_reset_in_n_i, .hard_reset_line_i, .hard_reset_line_o, .hard_reset_line_oe_n_o,
		.soft_reset_line_i, .soft_reset_line_o, .soft_reset_line_oe_n_o, .primary_clock_input_i,
		.agent_clock_input_i(primary_clock_input_i), .agent_mode_i(agent_mode), .pll_lock_i,
		.strap_pin_i, .strap_pin_o,
		.strap_pin_oe_n_o, .func_out_i, .reset_source_strap_o, .input_clock_divide_strap_o,
		.local_bus_mux_strap_o, .core_reset_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o);
	rsq_board u_rsq_board (.por_req_i(por_req), .ext_req_i(ext_req), .straps_i(straps),
		.hard_oe_n_i(hard_reset_line_oe_n_o), .soft_oe_n_i(soft_reset_line_oe_n_o),
		.strap_oe_n_i(strap_pin_oe_n_o), .strap_d_i(strap_pin_o), .por_n_o(power_on_reset_in_n_i),
		.pclk_o(primary_clock_input_i), .lock_o(pll_lock_i), .hard_line_o(hard_reset_line_i),
		.soft_line_o(soft_reset_line_i), .pin_o(strap_pin_i));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task results;
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask
	// bounded wait for the core reset level; a hang ends the run
	task wait_core(input logic v);
		for (int i = 0; i < 5000 && core_reset_o !== v; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		if (core_reset_o !== v)
		begin
			n_fail++;
			results();
		end
	endtask
	// main sequence: power-on, registers, software and outside restarts
	initial
	begin
		rst_i = 1'b1;
		{por_req, ext_req, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, agent_mode} = '0;
		straps = 6'h2b;
		func_out_i = 6'h15;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i) por_req <= 1'b1;
		repeat (100) @(posedge clk_i);
		chk({25'h0, hard_reset_line_oe_n_o, strap_pin_oe_n_o}, 32'h7f);
		wait_core(1'b0);
		chk({26'h0, local_bus_mux_strap_o, input_clock_divide_strap_o, reset_source_strap_o}, 32'h2b);
		chk({20'h0, strap_pin_oe_n_o, strap_pin_o}, 32'h15);
		rd_reg(4'h8, 32'h2b);
		wr_reg(4'h8, 32'hffff_ffff);
		rd_reg(4'h8, 32'h2b);
		rd_reg(4'h4, 32'h3f);
		wr_reg(4'h4, 32'h8);
		rd_reg(4'h4, 32'h37);
		rd_reg(4'hc, 32'h0);
		wr_reg(4'h0, 32'h2);
		rd_reg(4'h0, 32'h2);
		chk({31'h0, soft_reset_line_i}, 32'h0);
		wr_reg(4'h0, 32'h1);
		wait_core(1'b1);
		chk({26'h0, strap_pin_oe_n_o}, 32'h3f);
		wait_core(1'b0);
		rd_reg(4'h0, 32'h0);
		@(posedge clk_i) ext_req <= 1'b1;
		wait_core(1'b1);
		chk({26'h0, strap_pin_oe_n_o}, 32'h3f);
		wait_core(1'b0);
		por_req <= 1'b0;
		// second power-on with the divide strap set: ticks on every other edge
		straps <= 6'h34;
		@(posedge clk_i) por_req <= 1'b1;
		wait_core(1'b1);
		wait_core(1'b0);
		rd_reg(4'h8, 32'h34);
		// third power-on in agent mode; the agent clock follows the primary pin
		por_req <= 1'b0;
		agent_mode <= 1'b1;
		@(posedge clk_i) por_req <= 1'b1;
		wait_core(1'b1);
		wait_core(1'b0);
		rd_reg(4'h4, 32'h7f);
		results();
	end
endmodule
